// ===== core/ate_trigger_engine.sv
// module: trigger recognition engine with its AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ate_trigger_engine (
  // clock, reset, enable
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  input  wire logic                      clkEn,
  // probed samples and cross-module trigger
  input  wire ate_pkg::ate_sample_t      sample,
  input  wire logic                      sysTrigIn,
  output logic                           trigOut,
  output logic                           glitchStoreEn,
  // AXI4-Lite write
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [ate_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic [1:0]                     s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [ate_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp
);
  ate_pkg::ate_state_t  s, n;
  ate_pkg::ate_status_t stat;
  logic        armed, smp, evA, evB, evC, trigHit, inRng, chBit, chPrev, cond;
  logic        grpMatch, chanMatch, anyGrp, anyChan;
  logic [7:0]  grpSrc, grpDst, grpPrev;
  logic [15:0] hit;
  logic [31:0] wv, cnt1Nx, cnt2Nx;

  function automatic logic [31:0] byteMerge(input logic [31:0] o, input logic [31:0] d,
                                            input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      if (st[i]) o[8*i+:8] = d[8*i+:8];
    end
    return o;
  endfunction

  always_comb begin
    n = s;
    trigHit = 1'b0;
    wv = 32'h0;
    cnt1Nx = 32'h0;
    cnt2Nx = 32'h0;
    cond = 1'b0;
    stat = '0;
    // three-stage pin synchroniser; the level moves once stages two and three agree
    n.sysS1 = sysTrigIn;
    n.sysS2 = s.sysS1;
    n.sysS3 = s.sysS2;
    if (s.sysS2 == s.sysS3) n.sysFilt = s.sysS3;
    n.ctrl.manTrig = 1'b0;

    armed = s.ctrl.run && !s.trig;
    smp = armed && sample.valid;
    chBit = sample.data[s.cfg.chan];
    chPrev = s.prev[s.cfg.chan];
    grpSrc = sample.data[8*s.cfg.grp+:8];
    grpDst = sample.data[8*(s.cfg.grp ^ 2'h1)+:8];
    grpPrev = s.prev[8*s.cfg.grp+:8];
    anyGrp = 1'b0;
    anyChan = 1'b0;
    for (int i = 0; i < 4; i++) begin
      anyGrp = anyGrp | (sample.data[8*i+:8] == s.grp.val);
      anyChan = anyChan | (sample.data[8*i + 32'(s.cfg.chan[2:0])] == s.grp.val[0]);
    end
    case (s.cfg.demux)
      ate_pkg::DMX_2X: begin
        grpMatch = (grpSrc == s.grp.val) || (grpDst == s.grp.val);
        chanMatch = (chBit == s.grp.val[0])
                  || (sample.data[s.cfg.chan ^ 5'h08] == s.grp.val[0]);
      end
      ate_pkg::DMX_4X: begin
        grpMatch = anyGrp;
        chanMatch = anyChan;
      end
      default: begin
        grpMatch = grpSrc == s.grp.val;
        chanMatch = chBit == s.grp.val[0];
      end
    endcase
    // comparison assumes groups laid out in hardware bit order
    inRng = (grpSrc >= s.grp.lo) && (grpSrc <= s.grp.hi);

    hit = 16'h0;
    hit[ate_pkg::SRC_WORD] = ((sample.data ^ s.wordVal) & s.wordMask) == 32'h0;
    hit[ate_pkg::SRC_GRPVAL] = grpMatch;
    hit[ate_pkg::SRC_CHAN] = chanMatch;
    hit[ate_pkg::SRC_LEVEL] = chBit == s.cfg.edgePol[1];
    hit[ate_pkg::SRC_EDGE] = s.prevValid && (chBit != chPrev)
                           && ((s.cfg.edgePol == ate_pkg::POL_ANY)
                           || (s.cfg.edgePol == ate_pkg::POL_RISE && chBit)
                           || (s.cfg.edgePol == ate_pkg::POL_FALL && !chBit));
    hit[ate_pkg::SRC_GLITCH] = |(sample.glitch & s.grp.glitchMask);
    // faults are only meaningful when the probed system supplies the clock
    hit[ate_pkg::SRC_SETHOLD] = |(sample.fault & s.grp.glitchMask)
                              && (s.cfg.clkMode == ate_pkg::CLK_EXT
                              || s.cfg.clkMode == ate_pkg::CLK_CUSTOM);
    hit[ate_pkg::SRC_TRANS] = s.prevValid && (grpSrc != grpPrev);
    hit[ate_pkg::SRC_INRANGE] = inRng;
    hit[ate_pkg::SRC_OUTRANGE] = !inRng;
    evA = smp && hit[s.evSel.a];
    evB = smp && hit[s.evSel.b];
    evC = smp && hit[s.evSel.c];

    case (s.cfg.mode)
      ate_pkg::M_IMMED: trigHit = smp;
      ate_pkg::M_WAIT: trigHit = armed && (s.sysFilt || s.ctrl.manTrig);
      ate_pkg::M_EVENT: trigHit = evA;
      ate_pkg::M_SNAP: begin
        if (evA && !s.snapValid) begin
          n.snapValid = 1'b1;
          n.snap = sample.data;
        end else if (smp && s.snapValid && sample.data == s.snap) begin
          trigHit = 1'b1;
        end
      end
      ate_pkg::M_ACCCNT: if (evA) n.cnt1 = s.cnt1 + 32'h1;
      ate_pkg::M_ACCTIME: begin
        if (s.busy && armed) n.tmr1 = s.tmr1 + ate_pkg::CLK_STEP_NS;
        if (!s.busy && evA) n.busy = 1'b1;
        else if (s.busy && evB) n.busy = 1'b0;
      end
      ate_pkg::M_PULSE: begin
        // phase 0 waits for low so the first timed high phase is whole
        case (s.seqSt)
          4'h0: if (smp && !chBit) n.seqSt = 4'h1;
          4'h1: if (smp && chBit) begin
            n.seqSt = 4'h2;
            n.tmr1 = 32'h0;
          end
          4'h2: begin
            n.tmr1 = s.tmr1 + ate_pkg::CLK_STEP_NS;
            if (smp && !chBit) begin
              n.seqSt = 4'h3;
              n.tmr2 = 32'h0;
            end
          end
          4'h3: begin
            n.tmr2 = s.tmr2 + ate_pkg::CLK_STEP_NS;
            if (smp && chBit) trigHit = 1'b1;
          end
          default: n.seqSt = 4'h0;
        endcase
        if (!armed) n.seqSt = s.seqSt;
        if (!armed) n.tmr1 = s.tmr1;
        if (!armed) n.tmr2 = s.tmr2;
      end
      ate_pkg::M_MEASURE: begin
        if (!s.busy) begin
          if (evA) begin
            n.busy = 1'b1;
            n.tmr1 = 32'h0;
          end
        end else if (evC) begin
          n.busy = 1'b0;
        end else begin
          n.tmr1 = s.tmr1 + ate_pkg::CLK_STEP_NS;
          if (evB) begin
            n.busy = 1'b0;
            trigHit = 1'b1;
          end
        end
      end
      ate_pkg::M_PROFILE: if (armed) begin
        if (smp) n.cnt1 = inRng ? s.cnt1 + 32'h1 : s.cnt1 - 32'h1;
        n.tmr1 = s.tmr1 + ate_pkg::CLK_STEP_NS;
        trigHit = s.tmr1 + ate_pkg::CLK_STEP_NS >= s.limT;
      end
      ate_pkg::M_NSAMP: if (smp) begin
        n.cnt1 = s.cnt1 + 32'h1;
        trigHit = s.cnt1 + 32'h1 >= s.limN;
      end
      ate_pkg::M_ATIME: if (armed) begin
        n.tmr1 = s.tmr1 + ate_pkg::CLK_STEP_NS;
        trigHit = s.tmr1 + ate_pkg::CLK_STEP_NS >= s.limT;
      end
      ate_pkg::M_STACK: begin
        cnt1Nx = evA ? s.cnt1 + 32'h1 : s.cnt1;
        cnt2Nx = evB ? s.cnt2 + 32'h1 : s.cnt2;
        n.cnt1 = cnt1Nx;
        n.cnt2 = cnt2Nx;
        trigHit = smp && (cnt1Nx > s.limN || cnt2Nx > cnt1Nx);
      end
      ate_pkg::M_DUR, ate_pkg::M_WIDTH: if (armed) begin
        // the condition holds its last sampled level between samples
        if (!smp) cond = s.condPrev;
        else if (s.cfg.mode == ate_pkg::M_WIDTH) cond = chBit;
        else cond = s.ctrl.durPres ? hit[s.evSel.a] : !hit[s.evSel.a];
        n.condPrev = cond;
        if (cond) begin
          n.tmr1 = s.tmr1 + ate_pkg::CLK_STEP_NS;
          trigHit = !s.ctrl.durLe && (s.tmr1 + ate_pkg::CLK_STEP_NS > s.limT);
        end else begin
          n.tmr1 = 32'h0;
          trigHit = s.ctrl.durLe && s.condPrev && s.tmr1 != 32'h0
                  && s.tmr1 <= s.limT;
        end
      end
      ate_pkg::M_SEQ: begin
        // clause order is priority: the abandon clause outranks the advance clause
        if (s.ctrl.seqRst && evC && s.seqSt != 4'h0) begin
          n.seqSt = 4'h0;
        end else if (s.seqSt == 4'h0 ? evA : evB) begin
          if (s.seqSt + 4'h1 >= s.cfg.seqLen) trigHit = 1'b1;
          else n.seqSt = s.seqSt + 4'h1;
        end
      end
      ate_pkg::M_NTH: if (evA) begin
        n.cnt1 = s.cnt1 + 32'h1;
        trigHit = s.cnt1 + 32'h1 >= s.limN;
      end
      default: trigHit = 1'b0;
    endcase
    if (trigHit) n.trig = 1'b1;
    if (smp) begin
      n.prev = sample.data;
      n.prevValid = 1'b1;
    end
    n.glitchStore = armed && s.cfg.clkMode == ate_pkg::CLK_INT;

    stat.trig = s.trig;
    stat.armed = armed;
    stat.seqSt = s.seqSt;
    stat.snapValid = s.snapValid;

    // write channel; response only after both address and data are held
    if (s.bValid && s_axi_bready) n.bValid = 1'b0;
    if (s_axi_awvalid && s.awRdy) begin
      n.awHeld = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wRdy) begin
      n.wHeld = 1'b1;
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
    end
    if (s.awHeld && s.wHeld && !s.bValid) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bValid = 1'b1;
      n.bResp = ate_pkg::RESP_OKAY;
      case (s.awAddr)
        ate_pkg::OFF_CTRL: begin
          n.ctrl = ate_pkg::ate_ctrl_t'(byteMerge(s.ctrl, s.wData, s.wStrb));
          n.ctrl.rsvd = '0;
          n.ctrl.rsvd2 = '0;
          // a fresh run clears the previous capture and all measurements
          if (!s.ctrl.run && n.ctrl.run) begin
            n.trig = 1'b0;
            n.snapValid = 1'b0;
            n.prevValid = 1'b0;
            n.busy = 1'b0;
            n.condPrev = 1'b0;
            n.seqSt = 4'h0;
            n.cnt1 = 32'h0;
            n.cnt2 = 32'h0;
            n.tmr1 = 32'h0;
            n.tmr2 = 32'h0;
          end
        end
        ate_pkg::OFF_CFG: begin
          n.cfg = ate_pkg::ate_cfg_t'(byteMerge(s.cfg, s.wData, s.wStrb));
          n.cfg.rsvd = '0;
        end
        ate_pkg::OFF_EVSEL: begin
          n.evSel = ate_pkg::ate_evsel_t'(byteMerge(s.evSel, s.wData, s.wStrb));
          n.evSel.rsvd = '0;
        end
        ate_pkg::OFF_WVAL: n.wordVal = byteMerge(s.wordVal, s.wData, s.wStrb);
        ate_pkg::OFF_WMASK: n.wordMask = byteMerge(s.wordMask, s.wData, s.wStrb);
        ate_pkg::OFF_GRP: begin
          n.grp = ate_pkg::ate_grp_t'(byteMerge(s.grp, s.wData, s.wStrb));
          n.grp.rsvd = '0;
        end
        ate_pkg::OFF_LIMN: n.limN = byteMerge(s.limN, s.wData, s.wStrb);
        ate_pkg::OFF_LIMT: begin
          wv = byteMerge(s.limT, s.wData, s.wStrb);
          n.limT = wv & ate_pkg::RES_MASK;
        end
        ate_pkg::OFF_STATUS, ate_pkg::OFF_CNT1, ate_pkg::OFF_CNT2,
        ate_pkg::OFF_TMR1, ate_pkg::OFF_TMR2: n.bResp = ate_pkg::RESP_OKAY;
        default: n.bResp = ate_pkg::RESP_SLVERR;
      endcase
    end
    n.awRdy = !n.awHeld && !n.bValid;
    n.wRdy = !n.wHeld && !n.bValid;

    // read channel; counters stay readable after a halt
    if (s.rValid && s_axi_rready) n.rValid = 1'b0;
    if (s_axi_arvalid && s.arRdy) begin
      n.rValid = 1'b1;
      n.rResp = ate_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ate_pkg::OFF_CTRL: n.rData = s.ctrl;
        ate_pkg::OFF_CFG: n.rData = s.cfg;
        ate_pkg::OFF_EVSEL: n.rData = s.evSel;
        ate_pkg::OFF_WVAL: n.rData = s.wordVal;
        ate_pkg::OFF_WMASK: n.rData = s.wordMask;
        ate_pkg::OFF_GRP: n.rData = s.grp;
        ate_pkg::OFF_LIMN: n.rData = s.limN;
        ate_pkg::OFF_LIMT: n.rData = s.limT;
        ate_pkg::OFF_STATUS: n.rData = stat;
        ate_pkg::OFF_CNT1: n.rData = s.cnt1;
        ate_pkg::OFF_CNT2: n.rData = s.cnt2;
        ate_pkg::OFF_TMR1: n.rData = s.tmr1;
        ate_pkg::OFF_TMR2: n.rData = s.tmr2;
        default: begin
          n.rData = 32'h0;
          n.rResp = ate_pkg::RESP_SLVERR;
        end
      endcase
    end
    n.arRdy = !n.rValid;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) s <= ate_pkg::STATE_RST;
    else if (clkEn) s <= n;
  end

  assign trigOut       = s.trig;
  assign glitchStoreEn = s.glitchStore;
  assign s_axi_awready = s.awRdy;
  assign s_axi_wready  = s.wRdy;
  assign s_axi_bvalid  = s.bValid;
  assign s_axi_bresp   = s.bResp;
  assign s_axi_arready = s.arRdy;
  assign s_axi_rvalid  = s.rValid;
  assign s_axi_rdata   = s.rData;
  assign s_axi_rresp   = s.rResp;

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence smpTaken;
    clkEn && s.ctrl.run && !s.trig && sample.valid;
  endsequence
  sequence measureOpen;
    clkEn && s.cfg.mode == ate_pkg::M_MEASURE && s.busy;
  endsequence

  immed_trig_a: assert property (smpTaken ##0 (s.cfg.mode == ate_pkg::M_IMMED)
    |=> s.trig) else $error("immediate mode missed first sample");
  wait_hold_a: assert property (clkEn && s.cfg.mode == ate_pkg::M_WAIT && !s.trig
    && !s.sysFilt && !s.ctrl.manTrig |=> !s.trig) else $error("wait mode fired alone");
  edge_rise_a: assert property (smpTaken ##0 (s.cfg.mode == ate_pkg::M_EVENT
    && s.evSel.a == ate_pkg::SRC_EDGE && s.cfg.edgePol == ate_pkg::POL_RISE
    && s.prevValid && sample.data[s.cfg.chan] && !s.prev[s.cfg.chan]) |=> s.trig)
    else $error("rising edge not caught");
  snap_latch_a: assert property (clkEn && s.cfg.mode == ate_pkg::M_SNAP && evA
    && !s.snapValid |=> s.snapValid && s.snap == $past(sample.data))
    else $error("snapshot not latched");
  dmx_dest_a: assert property (smpTaken ##0 (s.cfg.mode == ate_pkg::M_EVENT
    && s.evSel.a == ate_pkg::SRC_GRPVAL && s.cfg.demux == ate_pkg::DMX_2X
    && sample.data[8*(s.cfg.grp ^ 2'h1)+:8] == s.grp.val) |=> s.trig)
    else $error("2X destination match ignored");
  glitch_store_a: assert property (clkEn && s.cfg.clkMode != ate_pkg::CLK_INT
    |=> !glitchStoreEn) else $error("glitch storage outside internal clocking");
  acc_count_a: assert property (smpTaken ##0 (s.cfg.mode == ate_pkg::M_ACCCNT
    && evA) |=> s.cnt1 == $past(s.cnt1) + 32'h1) else $error("count not accumulated");
  measure_abort_a: assert property (measureOpen ##0 evC
    |=> !s.busy && !s.trig) else $error("interval kept after reset event");
  limit_res_a: assert property ((s.limT & ~ate_pkg::RES_MASK) == 32'h0)
    else $error("time limit not on resolution grid");
  stack_under_a: assert property (smpTaken ##0 (s.cfg.mode == ate_pkg::M_STACK
    && evB && !evA && s.cnt2 == s.cnt1) |=> s.trig) else $error("underflow missed");
  seq_abandon_a: assert property (clkEn && s.cfg.mode == ate_pkg::M_SEQ
    && s.ctrl.seqRst && evC && s.seqSt != 4'h0 |=> s.seqSt == 4'h0 && !s.trig)
    else $error("abandon clause lost priority");
endmodule
`default_nettype wire

// ===== include/ate_pkg.sv
// package: shared types and constants of the acquisition trigger engine
package ate_pkg;
  localparam int          ADDR_W       = 8;
  localparam int          CLK_FREQ_MHZ = 200;
  localparam logic [31:0] CLK_STEP_NS  = 32'(1000 / CLK_FREQ_MHZ);
  localparam int          RES_NS       = 4;
  localparam logic [31:0] RES_MASK     = ~32'(RES_NS - 1);

  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CFG    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_EVSEL  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_WVAL   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_WMASK  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_GRP    = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_LIMN   = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_LIMT   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_CNT1   = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_CNT2   = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_TMR1   = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_TMR2   = 8'h30;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] POL_FALL    = 2'h1;
  localparam logic [1:0] POL_RISE    = 2'h2;
  localparam logic [1:0] POL_ANY     = 2'h3;

  typedef enum logic [3:0] {
    M_IMMED, M_WAIT, M_EVENT, M_SNAP, M_ACCCNT, M_ACCTIME, M_PULSE, M_MEASURE,
    M_PROFILE, M_NSAMP, M_ATIME, M_STACK, M_DUR, M_WIDTH, M_SEQ, M_NTH
  } ate_mode_t;

  typedef enum logic [3:0] {
    SRC_WORD, SRC_GRPVAL, SRC_CHAN, SRC_LEVEL, SRC_EDGE, SRC_GLITCH,
    SRC_SETHOLD, SRC_TRANS, SRC_INRANGE, SRC_OUTRANGE
  } ate_src_t;

  typedef enum logic [1:0] {CLK_INT, CLK_DRI, CLK_EXT, CLK_CUSTOM} ate_clk_t;
  typedef enum logic [1:0] {DMX_NONE, DMX_2X, DMX_4X, DMX_RSVD} ate_demux_t;

  typedef struct packed {
    logic [24:0] rsvd;
    logic        seqRst;
    logic        durLe;
    logic        durPres;
    logic [1:0]  rsvd2;
    logic        manTrig;
    logic        run;
  } ate_ctrl_t;

  typedef struct packed {
    logic [10:0] rsvd;
    logic [3:0]  seqLen;
    logic [1:0]  edgePol;
    logic [4:0]  chan;
    logic [1:0]  grp;
    ate_demux_t  demux;
    ate_clk_t    clkMode;
    ate_mode_t   mode;
  } ate_cfg_t;

  typedef struct packed {
    logic [19:0] rsvd;
    ate_src_t    c;
    ate_src_t    b;
    ate_src_t    a;
  } ate_evsel_t;

  typedef struct packed {
    logic [3:0] glitchMask;
    logic [3:0] rsvd;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] val;
  } ate_grp_t;

  typedef struct packed {
    logic [22:0] rsvd;
    logic        snapValid;
    logic [3:0]  seqSt;
    logic [1:0]  rsvd2;
    logic        armed;
    logic        trig;
  } ate_status_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  glitch;
    logic [3:0]  fault;
    logic [31:0] data;
  } ate_sample_t;

  typedef struct packed {
    logic awRdy, wRdy, awHeld, wHeld, bValid, arRdy, rValid;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic [1:0]  bResp, rResp;
    logic [31:0] rData;
    ate_ctrl_t   ctrl;
    ate_cfg_t    cfg;
    ate_evsel_t  evSel;
    ate_grp_t    grp;
    logic [31:0] wordVal, wordMask, limN, limT;
    logic        sysS1, sysS2, sysS3, sysFilt;
    logic        trig, glitchStore, snapValid, prevValid, busy, condPrev;
    logic [3:0]  seqSt;
    logic [31:0] snap, prev, cnt1, cnt2, tmr1, tmr2;
  } ate_state_t;

  localparam ate_state_t STATE_RST = '0;
endpackage

// ===== verif/ate_probe_model.sv
// probe model: the probed system presenting one acquired word per enabled cycle
`timescale 1ns/1ps
`default_nettype none
module ate_probe_model (
  // clock and control
  input  wire logic            clock,
  input  wire logic            en,
  input  wire logic [31:0]     word,
  // acquired sample
  output var ate_pkg::ate_sample_t sample
);
  // idle data is inverted so a stale word never looks valid; flags stay clear
  always @(posedge clock) begin
    sample <= '{valid: en, glitch: 4'h0, fault: 4'h0, data: en ? word : ~sample.data};
  end
endmodule
`default_nettype wire

// ===== verif/acquisition_trigger_engine_bench.sv
// bench: register bus, trigger mode, clock enable, glitch storage and counter checks
`timescale 1ns/1ps
`default_nettype none
module acquisition_trigger_engine_bench;
  logic                 clock, sysRst, clkEn, sysTrigIn, probeEn, trigOut, glitchSt;
  logic                 awv, wv, bRdy, arv, rRdy, awRdy, wRdy, bValid, arRdy, rValid;
  logic [7:0]           awa, ara;
  logic [31:0]          wd, probeWord, rdat, rData, w, tmp, cyc;
  logic [31:0]          seed = 32'h29;
  logic [1:0]           resp, bResp, rResp;
  logic [4:0]           ch;
  int                   miscompares, cmpCount, n;
  ate_pkg::ate_sample_t sample;

  ate_probe_model i_ate_probe_model (.clock(clock), .en(probeEn), .word(probeWord),
    .sample(sample));
  ate_trigger_engine i_ate_trigger_engine (.clock(clock), .sys_rst(sysRst), .clkEn(clkEn),
    .sample(sample), .sysTrigIn(sysTrigIn), .trigOut(trigOut), .glitchStoreEn(glitchSt),
    .s_axi_awvalid(awv), .s_axi_awready(awRdy), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wRdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bValid),
    .s_axi_bready(bRdy), .s_axi_bresp(bResp), .s_axi_arvalid(arv), .s_axi_arready(arRdy),
    .s_axi_araddr(ara), .s_axi_rvalid(rValid), .s_axi_rready(rRdy), .s_axi_rdata(rData),
    .s_axi_rresp(rResp));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test();
    if (miscompares == 0 && cmpCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ready is looked at on the falling edge, so it is the value the next rising edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clock);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bRdy <= 1'b1;
    do begin
      @(negedge clock);
      ta = awv & awRdy;
      tw = wv & wRdy;
      tb = bValid;
      resp = bResp;
      @(posedge clock);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb);
    bRdy <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge clock);
    ara <= a;
    arv <= 1'b1;
    rRdy <= 1'b1;
    do begin
      @(negedge clock);
      ta = arv & arRdy;
      tr = rValid;
      rdat = rData;
      resp = rResp;
      @(posedge clock);
      if (ta) arv <= 1'b0;
    end while (!tr);
    rRdy <= 1'b0;
  endtask

  task automatic arm(input logic [31:0] cfg);
    wr(ate_pkg::OFF_CTRL, 32'h0);
    wr(ate_pkg::OFF_CFG, cfg);
    wr(ate_pkg::OFF_CTRL, 32'h1);
  endtask

  task automatic feed(input int k, input logic [31:0] word);
    repeat (k) begin
      @(posedge clock);
      probeEn <= 1'b1;
      probeWord <= word;
    end
    @(posedge clock);
    probeEn <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'h4E20) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    {sysRst, clkEn, cyc} = {2'h3, 32'h0};
    {sysTrigIn, probeEn, probeWord, awv, wv, bRdy, arv, rRdy, awa, ara, wd} = '0;
    repeat (6) @(posedge clock);
    sysRst <= 1'b0;
    rd(ate_pkg::OFF_CFG);
    chk(rdat, 32'h0);
    rd(8'h34);
    chk(32'(resp), 32'(ate_pkg::RESP_SLVERR));
    arm(32'h0);
    chk(32'(trigOut), 32'h0);
    // a sample offered while the enable is low must not be taken
    clkEn <= 1'b0;
    feed(1, rnd());
    chk(32'(trigOut), 32'h0);
    chk(32'(glitchSt), 32'h1);
    clkEn <= 1'b1;
    feed(1, rnd());
    chk(32'(trigOut), 32'h1);
    for (int i = 0; i < 2; i++) begin
      arm(32'h1 | (32'(i) << 4));
      feed(5, rnd());
      chk(32'(trigOut), 32'h0);
      chk(32'(glitchSt), 32'(i == 0));
      if (i == 0) wr(ate_pkg::OFF_CTRL, 32'h3);
      else sysTrigIn <= 1'b1;
      repeat (8) @(posedge clock);
      chk(32'(trigOut), 32'h1);
      sysTrigIn <= 1'b0;
    end
    // every polarity: a rise first, then a fall
    for (int p = 1; p < 4; p++) begin
      tmp = rnd();
      ch = tmp[4:0];
      wr(ate_pkg::OFF_EVSEL, 32'(ate_pkg::SRC_EDGE));
      arm({15'h0, 2'(p), ch, 10'h002});
      w = rnd() & ~(32'h1 << ch);
      feed(3, w);
      chk(32'(trigOut), 32'h0);
      feed(2, w | (32'h1 << ch));
      chk(32'(trigOut), 32'(2'(p) != ate_pkg::POL_FALL));
      feed(2, w);
      chk(32'(trigOut), 32'h1);
    end
    tmp = rnd();
    n = 2 + int'(tmp[2:0]);
    wr(ate_pkg::OFF_LIMN, 32'(n)); // limit kept far below any pre-trigger share
    arm(32'h9);
    feed(n - 1, rnd());
    chk(32'(trigOut), 32'h0);
    feed(1, rnd());
    chk(32'(trigOut), 32'h1);
    // empty word mask: every sample is an occurrence
    wr(ate_pkg::OFF_EVSEL, 32'h0);
    arm(32'h4);
    feed(n, rnd());
    wr(ate_pkg::OFF_CTRL, 32'h0);
    feed(3, rnd());
    rd(ate_pkg::OFF_CNT1);
    chk(rdat, 32'(n));
    chk(32'(trigOut), 32'h0);
    tmp = rnd();
    arm(32'h3);
    feed(1, tmp);
    feed(1, ~tmp);
    chk(32'(trigOut), 32'h0);
    feed(1, tmp);
    chk(32'(trigOut), 32'h1);
    // stack: exits alone underflow at once, then entries alone pass the limit
    wr(ate_pkg::OFF_EVSEL, 32'h008);
    arm(32'hB);
    feed(1, rnd() | 32'h1);
    chk(32'(trigOut), 32'h1);
    wr(ate_pkg::OFF_EVSEL, 32'h080);
    arm(32'hB);
    feed(n, rnd() | 32'h1);
    chk(32'(trigOut), 32'h0);
    feed(1, rnd() | 32'h1);
    chk(32'(trigOut), 32'h1);
    // two-step sequence: low byte zero, then nonzero; with seqRst set the group change abandons it
    wr(ate_pkg::OFF_EVSEL, 32'h798);
    for (int j = 0; j < 2; j++) begin
      arm(32'h4000E);
      if (j == 1) wr(ate_pkg::OFF_CTRL, 32'h41);
      tmp = rnd() & 32'hFFFFFF00;
      feed(1, tmp);
      chk(32'(trigOut), 32'h0);
      feed(1, tmp | 32'h1);
      chk(32'(trigOut), 32'(j == 0));
    end
    finish_test();
  end
endmodule
`default_nettype wire
